// File: shared/irq_map_pkg.sv
// Constants for the interrupt source map and vector relocation block
package irq_map_pkg;
  // Exception line numbers and vector offsets
  localparam int unsigned LINE_SERIAL = 46;
  localparam int unsigned LINE_USB_LO = 47;
  localparam int unsigned LINE_USB_HI = 48;
  localparam int unsigned LINE_ADC = 49;
  localparam int unsigned LINE_WDOG = 50;
  localparam int unsigned LINE_BROWNOUT = 51;
  localparam int unsigned LINE_UNUSED = 52;
  localparam int unsigned LINE_PORT3 = 53;
  localparam int unsigned LINE_PORT2 = 54;
  localparam int unsigned LINE_PORT1 = 55;
  localparam int unsigned LINE_PORT0 = 56;
  localparam int unsigned LINE_FIRST = 46;
  localparam int unsigned NUM_LINES = 11;
  localparam logic [11:0] VEC_SERIAL = 12'h0B8;
  localparam logic [11:0] VEC_USB_LO = 12'h0BC;
  localparam logic [11:0] VEC_USB_HI = 12'h0C0;
  localparam logic [11:0] VEC_ADC = 12'h0C4;
  localparam logic [11:0] VEC_WDOG = 12'h0C8;
  localparam logic [11:0] VEC_BROWNOUT = 12'h0CC;
  localparam logic [11:0] VEC_PORT3 = 12'h0D4;
  localparam logic [11:0] VEC_PORT2 = 12'h0D8;
  localparam logic [11:0] VEC_PORT1 = 12'h0DC;
  localparam logic [11:0] VEC_PORT0 = 12'h0E0;
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_TABLE_BASE = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MASK = 12'h008;
  localparam logic [11:0] OFF_LINES = 12'h00C;
  // Reset values and field layout
  localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] TABLE_BASE_WMASK = 32'h3FFF_FC00;
  localparam int unsigned REGION_BIT = 29;
  localparam logic [10:0] MASK_RESET = 11'h000;
  localparam logic [10:0] UNUSED_LINE_MASK = 11'h040;
endpackage : irq_map_pkg

// File: src/vec_fetch_reg.sv
`timescale 1ns/1ps
// Registered vector address lookup: table base plus per-line offset
module vec_fetch_reg (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [31:0] base,
  input wire logic [5:0] line,
  output logic [31:0] addr
);
  import irq_map_pkg::*;
  // Exception number times four gives the offset in the table
  always_ff @(posedge clk) begin
    if (srst) begin
      addr <= 32'h0000_0000;
    end else if (ce) begin
      addr <= base + {24'h00_0000, line, 2'b00}; // RULE8
    end
  end
endmodule : vec_fetch_reg

// File: src/irq_source_map.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Interrupt source map onto exception lines 46..56 with relocatable vector table
// How it works
// RULE1 - The serial-port interrupt appears on line 46 at vector 0xB8 and includes receive line status.
// RULE2 - Transmit empty, receive data, character timeout, autobaud done and autobaud timeout are ORed onto line 46.
// RULE3 - The converter end of conversion raises line 49 at vector 0xC4.
// RULE4 - Port 3 combined status drives line 53 at vector 0xD4.
// RULE5 - Port 2 combined status drives line 54 at vector 0xD8.
// RULE6 - Port 1 combined status drives line 55 at vector 0xDC.
// RULE7 - Port 0 combined status drives line 56 at vector 0xE0.
// RULE8 - Vectors are fetched relative to the table offset register.
// RULE9 - Any table base within the lowest 1 GB is accepted.
// RULE10 - Software places a relocated table on a 1024-byte boundary.
// RULE11 - Bit 29 of the table offset is an ordinary address bit: code when 0, SRAM when 1.
// RULE12 - USB low on 47, USB high on 48, watchdog on 50, brown-out on 51, line 52 never used.
module irq_source_map (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Peripheral request lines
  input wire logic rx_line_status_flag,
  input wire logic tx_holding_empty_flag,
  input wire logic rx_data_available_flag,
  input wire logic char_timeout_flag,
  input wire logic autobaud_done_flag,
  input wire logic autobaud_timeout_flag,
  input wire logic USB_LOW_IRQ,
  input wire logic fast_priority_request,
  input wire logic ADC_DONE,
  input wire logic watchdog_irq_flag,
  input wire logic BROWNOUT_IRQ,
  input wire logic gpio_port0_line,
  input wire logic gpio_port1_line,
  input wire logic gpio_port2_line,
  input wire logic gpio_port3_line,
  // Core side
  input wire logic FETCH_REQ,
  input wire logic [5:0] FETCH_LINE,
  output logic [56:46] EXC_LINES,
  output logic [31:0] VECTOR_ADDR,
  output logic FETCH_VALID,
  output logic IRQ
);
  import irq_map_pkg::*;

  // Register map, byte addresses, one aligned word each:
  //   0x000 table base, bits 29:10 writable, the rest read as zero
  //   0x004 status, bit i is line 46+i, write one to clear
  //   0x008 mask, same layout, spare line bit stays zero
  //   0x00C live line levels, read only
  // Any other address answers with an error; writes dropped, reads zero.
  // Bus handshake seen from here:
  //   setup edge   select high, enable low, ready and read word launched
  //   access edge  ready sampled high, write lands, read word taken
  //   after that   ready drops by itself, no wait states while the enable is high
  // Timing, counted in enabled clock edges:
  //   source level to line output and status bit: one edge
  //   status bit to interrupt output: one more edge
  //   fetch request to fetch valid: one edge
  //   fetch line to vector address: two edges, so the address
  //   trails the valid flag by one cycle; hold the line number
  //   for two cycles and take the address the cycle after valid
  // With the enable low nothing moves, bus replies included:
  // a setup edge lost that way leaves ready low for good, and a write whose access edge is lost is dropped.

  // Bus phase as seen by this slave
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_ACCESS = 2'b10
  } apb_phase_t;

  apb_phase_t phase_reg;
  apb_phase_t phase_next;
  logic [10:0] line_now;
  logic [31:0] vector_table_offset_reg;
  logic table_region_select_bit;
  logic [10:0] status_reg;
  logic [10:0] mask_reg;
  logic [10:0] pending;
  logic [31:0] prdata_next;
  logic setup;
  logic access;
  logic wr;
  logic wr_base;
  logic wr_status;
  logic wr_mask;
  logic [31:0] fetch_addr;

  // Serial-port line merges all six uart conditions
  function automatic logic serial_merge(input logic [5:0] f);
    serial_merge = |f;
  endfunction : serial_merge

  // Decode used by reads and writes alike
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == OFF_TABLE_BASE) || (a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_LINES);
  endfunction : is_mapped

  // Source to line routing, bit i is exception line 46+i
  always_comb begin
    line_now = 11'h000;
    // Serial port, six conditions on one line
    line_now[LINE_SERIAL - LINE_FIRST] = serial_merge({rx_line_status_flag, // RULE1
      tx_holding_empty_flag, rx_data_available_flag, char_timeout_flag, // RULE2
      autobaud_done_flag, autobaud_timeout_flag}); // RULE2
    // USB, converter, watchdog and brown-out, one source each
    line_now[LINE_USB_LO - LINE_FIRST] = USB_LOW_IRQ; // RULE12
    line_now[LINE_USB_HI - LINE_FIRST] = fast_priority_request; // RULE12
    line_now[LINE_ADC - LINE_FIRST] = ADC_DONE; // RULE3
    line_now[LINE_WDOG - LINE_FIRST] = watchdog_irq_flag; // RULE12
    line_now[LINE_BROWNOUT - LINE_FIRST] = BROWNOUT_IRQ; // RULE12
    // Spare line tied low, software never sees it pending
    line_now[LINE_UNUSED - LINE_FIRST] = 1'b0; // RULE12
    // Ports, highest port on the lowest line
    line_now[LINE_PORT3 - LINE_FIRST] = gpio_port3_line; // RULE4
    line_now[LINE_PORT2 - LINE_FIRST] = gpio_port2_line; // RULE5
    line_now[LINE_PORT1 - LINE_FIRST] = gpio_port1_line; // RULE6
    line_now[LINE_PORT0 - LINE_FIRST] = gpio_port0_line; // RULE7
  end

  // Lines to the core, registered so every output is a flop
  always_ff @(posedge CLK) begin
    if (SRST) begin
      EXC_LINES <= 11'h000;
    end else if (CE) begin
      EXC_LINES <= line_now;
    end
  end

  // Next bus phase from the request lines alone
  always_comb begin
    phase_next = PH_IDLE;
    case ({PSEL, PENABLE})
      2'b10: phase_next = PH_SETUP;
      2'b11: phase_next = PH_ACCESS;
      default: phase_next = PH_IDLE;
    endcase
  end

  // Phase tracker
  always_ff @(posedge CLK) begin
    if (SRST) begin
      phase_reg <= PH_IDLE;
    end else if (CE) begin
      phase_reg <= phase_next;
    end
  end

  // Only the access cycle right after a setup may write: a lingering master cannot write twice
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && (phase_reg == PH_SETUP);
  assign wr = access && PWRITE && is_mapped(PADDR);
  assign wr_base = wr && (PADDR == OFF_TABLE_BASE);
  assign wr_status = wr && (PADDR == OFF_STATUS);
  assign wr_mask = wr && (PADDR == OFF_MASK);

  // Table offset: low ten bits forced to zero, top two bits kept zero for 1 GB reach
  always_ff @(posedge CLK) begin
    if (SRST) begin
      vector_table_offset_reg <= TABLE_BASE_RESET;
    end else if (CE && wr_base) begin
      vector_table_offset_reg <= PWDATA & TABLE_BASE_WMASK; // RULE9 RULE11
    end
  end

  // Region bit is just one more address bit, no special decode
  assign table_region_select_bit = vector_table_offset_reg[REGION_BIT]; // RULE11

  // Sticky status, one flop per line; set beats a write-one clear in the same cycle
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_status
    always_ff @(posedge CLK) begin
      if (SRST) begin
        status_reg[i] <= 1'b0;
      end else if (CE) begin
        if (line_now[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr_status && PWDATA[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Mask, reserved line bit never settable
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_reg <= MASK_RESET;
    end else if (CE && wr_mask) begin
      mask_reg <= PWDATA[10:0] & ~UNUSED_LINE_MASK; // RULE12
    end
  end

  // Unmasked events
  assign pending = status_reg & mask_reg;

  // One level interrupt, high while an unmasked status bit stands
  always_ff @(posedge CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |pending;
    end
  end

  // Read mux
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (PADDR)
      OFF_TABLE_BASE: prdata_next = {vector_table_offset_reg[31:30], table_region_select_bit,
        vector_table_offset_reg[28:0]};
      OFF_STATUS: prdata_next = {21'h00_0000, status_reg};
      OFF_MASK: prdata_next = {21'h00_0000, mask_reg};
      OFF_LINES: prdata_next = {21'h00_0000, EXC_LINES};
      default: prdata_next = 32'h0000_0000;
    endcase
  end

  // Ready pulses in the access cycle that follows each setup cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
    end else if (CE) begin
      PREADY <= setup;
    end
  end

  // Error flag rides with ready for addresses outside the map
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PSLVERR <= setup && !is_mapped(PADDR);
    end
  end

  // Read word captured at setup, steady through the access cycle; zero otherwise
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (CE) begin
      PRDATA <= (setup && !PWRITE) ? prdata_next : 32'h0000_0000;
    end
  end

  // Vector address from relocated base; the adder sits behind its own flop
  // so the wide carry chain never meets the output flop in one cycle
  vec_fetch_reg u_fetch (
    .clk(CLK),
    .srst(SRST),
    .ce(CE),
    .base(vector_table_offset_reg),
    .line(FETCH_LINE),
    .addr(fetch_addr)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      FETCH_VALID <= 1'b0;
    end else if (CE) begin
      FETCH_VALID <= FETCH_REQ;
    end
  end

  // Address lands one cycle after the valid flag, two after the line number
  always_ff @(posedge CLK) begin
    if (SRST) begin
      VECTOR_ADDR <= 32'h0000_0000;
    end else if (CE) begin
      VECTOR_ADDR <= fetch_addr; // RULE8
    end
  end
endmodule : irq_source_map

// File: test/irq_map_monitor.sv
// Checker for line mapping and vector fetch timing
`timescale 1ns/1ps
module irq_map_monitor import irq_map_pkg::*; (
  input wire logic CLK, SRST, CE, PSEL, PENABLE, PWRITE, PREADY, FETCH_REQ, FETCH_VALID,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, VECTOR_ADDR,
  input wire logic [5:0] FETCH_LINE,
  input wire logic [56:46] EXC_LINES,
  input wire logic rx_line_status_flag, tx_holding_empty_flag, rx_data_available_flag, char_timeout_flag,
  input wire logic autobaud_done_flag, autobaud_timeout_flag, USB_LOW_IRQ, fast_priority_request, ADC_DONE,
  input wire logic watchdog_irq_flag, BROWNOUT_IRQ, gpio_port0_line, gpio_port1_line, gpio_port2_line, gpio_port3_line
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [31:0] base_reg;
  // Shadow of the table base, so fetched addresses can be predicted
  always_ff @(posedge CLK) begin
    if (SRST) base_reg <= 32'h0000_0000;
    else if (CE && PSEL && PENABLE && PREADY && PWRITE && PADDR == OFF_TABLE_BASE) base_reg <= PWDATA & TABLE_BASE_WMASK;
  end
  property p_serial; CE |=> EXC_LINES[46] == $past(|{rx_line_status_flag, tx_holding_empty_flag,
    rx_data_available_flag, char_timeout_flag, autobaud_done_flag, autobaud_timeout_flag}); endproperty
  a_serial: assert property (p_serial) else $error("serial line");
  property p_adc; CE |=> EXC_LINES[49] == $past(ADC_DONE); endproperty
  a_adc: assert property (p_adc) else $error("converter line");
  property p_port_hi; CE |=> EXC_LINES[54:53] == $past({gpio_port2_line, gpio_port3_line}); endproperty
  a_port_hi: assert property (p_port_hi) else $error("port 2/3 line");
  property p_port_lo; CE |=> EXC_LINES[56:55] == $past({gpio_port0_line, gpio_port1_line}); endproperty
  a_port_lo: assert property (p_port_lo) else $error("port 0/1 line");
  property p_misc; CE |=> {EXC_LINES[51:50], EXC_LINES[48:47]} ==
    $past({BROWNOUT_IRQ, watchdog_irq_flag, fast_priority_request, USB_LOW_IRQ}); endproperty
  a_misc: assert property (p_misc) else $error("usb, watchdog or brownout line");
  property p_unused; EXC_LINES[52] == 1'b0; endproperty
  a_unused: assert property (p_unused) else $error("spare line raised");
  property p_fvalid; CE |=> FETCH_VALID == $past(FETCH_REQ); endproperty
  a_fvalid: assert property (p_fvalid) else $error("fetch valid timing");
  property p_addr; FETCH_VALID |=> VECTOR_ADDR == base_reg + {$past(FETCH_LINE, 2), 2'b00}; endproperty
  a_addr: assert property (p_addr) else $error("vector address");
endmodule : irq_map_monitor
bind irq_source_map irq_map_monitor i_irq_map_monitor (.*);

// File: test/periph_model.sv
// Peripheral request lines as registered levels
`timescale 1ns/1ps
module periph_model (
  input wire logic CLK,
  input wire logic [14:0] src_in,
  output logic [14:0] src
);
  // Flags move only on the clock, like real status registers
  always_ff @(posedge CLK) begin
    src <= src_in;
  end
endmodule : periph_model

// File: test/tb.sv
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps
module tb;
  import irq_map_pkg::*;
  logic CLK = 0, SRST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, FETCH_REQ = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, VECTOR_ADDR, rd;
  logic [5:0] FETCH_LINE = 6'h00;
  logic [56:46] EXC_LINES;
  logic [14:0] src_in = 15'h0000, src;
  logic PREADY, PSLVERR, FETCH_VALID, IRQ, err;
  logic rx_line_status_flag, tx_holding_empty_flag, rx_data_available_flag, char_timeout_flag, autobaud_done_flag;
  logic autobaud_timeout_flag, USB_LOW_IRQ, fast_priority_request, ADC_DONE, watchdog_irq_flag, BROWNOUT_IRQ;
  logic gpio_port0_line, gpio_port1_line, gpio_port2_line, gpio_port3_line;
  logic [31:0] vt [4];
  int mismatches = 0, tests_run = 0, seed = 32'h02A99E38;
  // Source bits: 0..5 serial flags, 6..10 single lines, 11..14 ports 3..0
  assign {gpio_port0_line, gpio_port1_line, gpio_port2_line, gpio_port3_line, BROWNOUT_IRQ, watchdog_irq_flag,
    ADC_DONE, fast_priority_request, USB_LOW_IRQ, autobaud_timeout_flag, autobaud_done_flag, char_timeout_flag,
    rx_data_available_flag, tx_holding_empty_flag, rx_line_status_flag} = src;
  always #25 CLK = ~CLK;
  periph_model i_periph_model (.CLK(CLK), .src_in(src_in), .src(src));
  irq_source_map i_irq_source_map (.*);
  function automatic logic [10:0] exp_lines(logic [14:0] s);
    return {s[14:11], 1'b0, s[10:6], |s[5:0]};
  endfunction : exp_lines
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask : chk
  // One APB transfer; waits on the slave's ready, not a fixed count
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  // Model lag plus line register, with two spare cycles
  task automatic drive(logic [14:0] s);
    src_in <= s;
    repeat (4) @(posedge CLK);
  endtask : drive
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Main sequence: lines, interrupt, unmapped access, relocation
  initial begin
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      drive(i < 15 ? 15'h0001 << i : 15'($random(seed)));
      chk("lines", 32'(exp_lines(src_in)), 32'(EXC_LINES));
    end
    drive(15'h0000);
    // Enable low: every source rises, nothing may move
    CE <= 1'b0;
    drive(15'h7FFF);
    chk("frozen lines", 32'h0000_0000, 32'(EXC_LINES));
    CE <= 1'b1;
    drive(15'h0000);
    apb(1'b1, OFF_STATUS, 32'h0000_07FF);
    apb(1'b1, OFF_MASK, 32'h0000_0048);
    apb(1'b0, OFF_MASK, 32'h0000_0000);
    chk("mask", 32'h0000_0008, rd);
    drive(15'h0200);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0010, rd);
    chk("masked irq", 32'h0000_0000, 32'(IRQ));
    drive(15'h0100);
    chk("irq", 32'h0000_0001, 32'(IRQ));
    drive(15'h0000);
    apb(1'b1, OFF_STATUS, 32'h0000_0008);
    repeat (2) @(posedge CLK);
    chk("cleared irq", 32'h0000_0000, 32'(IRQ));
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    chk("error flag", 32'h0000_0001, 32'(err));
    chk("unmapped read", 32'h0000_0000, rd);
    vt = '{32'h1000_0000, 32'h2000_0400, 32'hFFFF_FFFF, 32'($random(seed)) & TABLE_BASE_WMASK};
    foreach (vt[k]) begin
      apb(1'b1, OFF_TABLE_BASE, vt[k]);
      apb(1'b0, OFF_TABLE_BASE, 32'h0000_0000);
      chk("table base", vt[k] & TABLE_BASE_WMASK, rd);
      for (int l = LINE_FIRST; l < LINE_FIRST + NUM_LINES; l++) begin
        FETCH_LINE <= 6'(l);
        FETCH_REQ <= 1'b1;
        @(posedge CLK) FETCH_REQ <= 1'b0;
        repeat (2) @(posedge CLK);
        chk("vector", (vt[k] & TABLE_BASE_WMASK) + 32'(l * 4), VECTOR_ADDR);
      end
    end
    test_done();
  end
  // Hang guard, well past the expected run of under a thousand cycles
  initial begin
    repeat (3000) @(posedge CLK);
    mismatches++;
    test_done();
  end
endmodule : tb
